// [src/asf_cfg.svh]
// Purpose: Constants of the arithmetic flags block.
// Assumes: One core clock, flags held in the low five bits.
// Notes:   Included by the flags module only.
//
// Behaviour
// [RULE_01] Flags register is a normal source or destination operand of any instruction.
// [RULE_02] Flag-updating op aimed at flags register: write blocked, bits come from ALU.
// [RULE_03] Clear-file on flags register sets zero flag only; others stay.
// [RULE_04] Software should alter flags only with non-flag ops: bit, swap, moves.
// [RULE_05] Subtract adds two's complement; carry and nibble carry mean no-borrow.
// [RULE_06] Program memory is reached only through the program counter.
// [RULE_07] Data memory reached by inherent, literal, direct and indirect modes.
// [RULE_08] Mode fixed per instruction, some pick among three by operands and set.
// [RULE_09] Indexed literal offset mode exists only when extended set bit is one.
// [RULE_10] Enabling extended set changes execution of some core instructions.
// [RULE_11] N is MSB, Z all-zero, nibble carry bit 3, carry MSB, OV signed.
// [RULE_12] Upper three flag bits read zero and ignore writes.
`ifndef ASF_CFG_SVH
`define ASF_CFG_SVH
`define ASF_BIT_C        0
`define ASF_BIT_DC       1
`define ASF_BIT_Z        2
`define ASF_BIT_OV       3
`define ASF_BIT_N        4
`define ASF_FLAGS_RST    5'h00
`define ASF_ACCESS_SPLIT 8'h60
`define ASF_SFR_PAGE     4'hF
`define ASF_INDEX_PAGE   4'h0
`endif

// [src/asf_flags.sv]
// Purpose: ALU flag generation, flags register and data address resolution.
// Assumes: Datapath presents one instruction per op_valid cycle.
// Notes:   Extended set strap is caught on the first edge after reset release.
`timescale 1ns/100ps
`include "asf_cfg.svh"
module asf_flags #(
	parameter int AW = 12
) (
	input  wire logic              clk_sys,
	input  wire logic              rst,
	input  wire logic              ext_strap,
	input  wire logic              op_valid,
	input  wire asf_pkg::asf_op_e  alu_op,
	input  wire logic [7:0]        opd_a,
	input  wire logic [7:0]        opd_b,
	input  wire logic              src_is_flags,
	input  wire logic              dest_is_flags,
	input  wire logic              addr_req,
	input  wire asf_pkg::asf_mode_e addr_mode,
	input  wire logic [7:0]        addr_lit,
	input  wire logic [3:0]        bank_sel,
	input  wire logic [AW-1:0]     fsr_ptr,
	input  wire logic [AW-1:0]     fsr2_ptr,
	output logic [7:0]             flags_rd,
	output logic [7:0]             result_ff,
	output logic [AW-1:0]          data_addr_ff,
	output logic                   addr_vld_ff,
	output logic                   addr_err_ff,
	output logic                   ext_set_active
);
	// ----------------------------------------
	// Parameter check.
	// ----------------------------------------
	if (AW != 12) begin : g_bad_aw
		$error("asf_flags: address width must be 12");
	end

	asf_pkg::asf_state_s state_ff;
	asf_pkg::asf_state_s nxt_state;

	logic [7:0] src_a;
	logic [7:0] eff_b;
	logic       cin;
	logic [8:0] sum;
	logic [4:0] nib;
	logic [7:0] res;
	logic [4:0] alu_flags;
	logic [4:0] upd_mask;

	// ----------------------------------------
	// ALU and flag generation.
	// ----------------------------------------
	always_comb begin
		src_a     = src_is_flags ? {3'h0, state_ff.flags} : opd_a; // RULE_01
		eff_b     = opd_b;
		cin       = 1'b0;
		upd_mask  = 5'h00;
		res       = 8'h00;
		alu_flags = state_ff.flags;
		case (alu_op)
			asf_pkg::ASF_OP_ADD: begin
				upd_mask = 5'h1F;
			end
			asf_pkg::ASF_OP_ADDC: begin
				cin      = state_ff.flags[`ASF_BIT_C];
				upd_mask = 5'h1F;
			end
			asf_pkg::ASF_OP_SUB: begin
				eff_b    = ~opd_b; // RULE_05
				cin      = 1'b1;
				upd_mask = 5'h1F;
			end
			asf_pkg::ASF_OP_SUBB: begin
				eff_b    = ~opd_b; // RULE_05
				cin      = state_ff.flags[`ASF_BIT_C];
				upd_mask = 5'h1F;
			end
			asf_pkg::ASF_OP_AND,
			asf_pkg::ASF_OP_IOR,
			asf_pkg::ASF_OP_XOR: begin
				upd_mask = 5'h14;
			end
			asf_pkg::ASF_OP_CLR: begin
				upd_mask = 5'h04; // RULE_03
			end
			default: begin
				upd_mask = 5'h00; // RULE_04
			end
		endcase
		sum = {1'b0, src_a} + {1'b0, eff_b} + {8'h00, cin};
		nib = {1'b0, src_a[3:0]} + {1'b0, eff_b[3:0]} + {4'h0, cin};
		case (alu_op)
			asf_pkg::ASF_OP_AND:  res = src_a & opd_b;
			asf_pkg::ASF_OP_IOR:  res = src_a | opd_b;
			asf_pkg::ASF_OP_XOR:  res = src_a ^ opd_b;
			asf_pkg::ASF_OP_CLR:  res = 8'h00;
			asf_pkg::ASF_OP_PASS: res = src_a;
			default:              res = sum[7:0];
		endcase
		alu_flags[`ASF_BIT_N]  = res[7]; // RULE_11
		alu_flags[`ASF_BIT_Z]  = (res == 8'h00); // RULE_11
		alu_flags[`ASF_BIT_C]  = sum[8]; // RULE_05
		alu_flags[`ASF_BIT_DC] = nib[4]; // RULE_05
		alu_flags[`ASF_BIT_OV] = (src_a[7] == eff_b[7]) && (res[7] != src_a[7]); // RULE_11
	end

	// ----------------------------------------
	// Next state.
	// ----------------------------------------
	always_comb begin
		nxt_state          = state_ff;
		nxt_state.addr_vld = 1'b0;
		nxt_state.addr_err = 1'b0;
		if (!state_ff.ext_cap) begin
			nxt_state.ext_cap = 1'b1;
			nxt_state.ext_en  = ext_strap;
		end
		if (op_valid) begin
			nxt_state.result = res;
			if (dest_is_flags && upd_mask == 5'h00) begin
				nxt_state.flags = res[4:0]; // RULE_12
			end else begin
				nxt_state.flags = (alu_flags & upd_mask) | (state_ff.flags & ~upd_mask); // RULE_02
			end
		end
		if (addr_req) begin
			nxt_state.addr_vld = 1'b1;
			case (addr_mode) // RULE_07
				asf_pkg::ASF_AM_ACCESS: begin
					if (addr_lit < `ASF_ACCESS_SPLIT && state_ff.ext_en) begin
						nxt_state.addr = fsr2_ptr + {4'h0, addr_lit}; // RULE_10
					end else if (addr_lit < `ASF_ACCESS_SPLIT) begin
						nxt_state.addr = {`ASF_INDEX_PAGE, addr_lit};
					end else begin
						nxt_state.addr = {`ASF_SFR_PAGE, addr_lit};
					end
				end
				asf_pkg::ASF_AM_BANKED:   nxt_state.addr = {bank_sel, addr_lit};
				asf_pkg::ASF_AM_INDIRECT: nxt_state.addr = fsr_ptr;
				asf_pkg::ASF_AM_INDEXED: begin
					nxt_state.addr     = fsr2_ptr + {4'h0, addr_lit};
					nxt_state.addr_vld = state_ff.ext_en; // RULE_09
					nxt_state.addr_err = !state_ff.ext_en; // RULE_09
				end
				default: begin
					nxt_state.addr_vld = 1'b0; // RULE_08
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_ff <= '{flags: `ASF_FLAGS_RST, result: 8'h00, addr: 12'h000,
				addr_vld: 1'b0, addr_err: 1'b0, ext_en: 1'b0, ext_cap: 1'b0};
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Data address is twelve bits only; program memory is never addressed here.
	assign data_addr_ff   = state_ff.addr; // RULE_06
	assign flags_rd       = {3'h0, state_ff.flags}; // RULE_12
	assign result_ff      = state_ff.result;
	assign addr_vld_ff    = state_ff.addr_vld;
	assign addr_err_ff    = state_ff.addr_err;
	assign ext_set_active = state_ff.ext_en;

	// ----------------------------------------
	// Assertions.
	// ----------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence s_clr_flags;
		op_valid && alu_op == asf_pkg::ASF_OP_CLR && dest_is_flags;
	endsequence
	sequence s_add_to_flags;
		op_valid && alu_op == asf_pkg::ASF_OP_ADD && dest_is_flags;
	endsequence
	sequence s_arith;
		op_valid && alu_op inside {asf_pkg::ASF_OP_ADD, asf_pkg::ASF_OP_SUB};
	endsequence

	property p_clr_zero_only;
		s_clr_flags |=> flags_rd[`ASF_BIT_Z] && flags_rd[1:0] == $past(flags_rd[1:0])
			&& flags_rd[4:3] == $past(flags_rd[4:3]);
	endproperty
	a_clr_zero_only: assert property (p_clr_zero_only) else $error("clear did not set Z alone"); // RULE_03

	property p_block_write;
		s_add_to_flags |=> flags_rd[4:0] == $past(alu_flags);
	endproperty
	a_block_write: assert property (p_block_write) else $error("flags write not blocked"); // RULE_02

	property p_neg_zero;
		s_arith |=> flags_rd[`ASF_BIT_N] == result_ff[7]
			&& flags_rd[`ASF_BIT_Z] == (result_ff == 8'h00);
	endproperty
	a_neg_zero: assert property (p_neg_zero) else $error("N or Z wrong"); // RULE_11

	property p_sub_borrow;
		op_valid && alu_op == asf_pkg::ASF_OP_SUB && !src_is_flags
			|=> flags_rd[`ASF_BIT_C] == ($past(opd_a) >= $past(opd_b));
	endproperty
	a_sub_borrow: assert property (p_sub_borrow) else $error("borrow polarity wrong"); // RULE_05

	property p_upper_zero;
		flags_rd[7:5] == 3'h0;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("upper flag bits not zero"); // RULE_12

	property p_move_to_flags;
		op_valid && alu_op == asf_pkg::ASF_OP_PASS && dest_is_flags && !src_is_flags
			|=> flags_rd[4:0] == $past(opd_a[4:0]);
	endproperty
	a_move_to_flags: assert property (p_move_to_flags) else $error("move to flags lost"); // RULE_01

	property p_move_keeps;
		op_valid && alu_op == asf_pkg::ASF_OP_PASS && !dest_is_flags
			|=> $stable(flags_rd);
	endproperty
	a_move_keeps: assert property (p_move_keeps) else $error("move altered flags"); // RULE_04

	property p_index_gate;
		addr_req && addr_mode == asf_pkg::ASF_AM_INDEXED
			|=> addr_err_ff == !$past(ext_set_active) && addr_vld_ff == $past(ext_set_active);
	endproperty
	a_index_gate: assert property (p_index_gate) else $error("indexed mode gate wrong"); // RULE_09

	property p_access_high;
		addr_req && addr_mode == asf_pkg::ASF_AM_ACCESS && addr_lit >= `ASF_ACCESS_SPLIT
			|=> addr_vld_ff && data_addr_ff == {`ASF_SFR_PAGE, $past(addr_lit)};
	endproperty
	a_access_high: assert property (p_access_high) else $error("access bank SFR wrong"); // RULE_07

	property p_no_addr_inherent;
		addr_req && addr_mode inside {asf_pkg::ASF_AM_INHERENT, asf_pkg::ASF_AM_LITERAL}
			|=> !addr_vld_ff;
	endproperty
	a_no_addr_inherent: assert property (p_no_addr_inherent) else $error("spurious address"); // RULE_08
endmodule : asf_flags

// [src/asf_pkg.sv]
// Purpose: Types of the arithmetic flags block.
// Assumes: Nothing beyond the core clock.
// Notes:   Constants live in asf_cfg.svh.
package asf_pkg;
	typedef enum logic [3:0] {
		ASF_OP_ADD  = 4'h0,
		ASF_OP_ADDC = 4'h1,
		ASF_OP_SUB  = 4'h2,
		ASF_OP_SUBB = 4'h3,
		ASF_OP_AND  = 4'h4,
		ASF_OP_IOR  = 4'h5,
		ASF_OP_XOR  = 4'h6,
		ASF_OP_CLR  = 4'h7,
		ASF_OP_PASS = 4'h8
	} asf_op_e;
	typedef enum logic [2:0] {
		ASF_AM_INHERENT = 3'h0,
		ASF_AM_LITERAL  = 3'h1,
		ASF_AM_ACCESS   = 3'h2,
		ASF_AM_BANKED   = 3'h3,
		ASF_AM_INDIRECT = 3'h4,
		ASF_AM_INDEXED  = 3'h5
	} asf_mode_e;
	typedef struct packed {
		logic [4:0]  flags;
		logic [7:0]  result;
		logic [11:0] addr;
		logic        addr_vld;
		logic        addr_err;
		logic        ext_en;
		logic        ext_cap;
	} asf_state_s;
endpackage : asf_pkg

// [tb/alu_status_flags_bench.sv]
// Purpose: Self-checking bench of the arithmetic flags block.
// Assumes: Results appear one cycle after the request edge.
// Notes:   Second reset runs with the extended set strap high.
`timescale 1ns/100ps
module alu_status_flags_bench;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic ext_strap = 1'b0;
	logic op_valid, src_is_flags, dest_is_flags, addr_req;
	logic [7:0] opd_a, opd_b, addr_lit, flags_rd, result_ff;
	logic [3:0] bank_sel;
	logic [11:0] fsr_ptr, fsr2_ptr, data_addr_ff;
	logic addr_vld_ff, addr_err_ff, ext_set_active;
	asf_pkg::asf_op_e alu_op;
	asf_pkg::asf_mode_e addr_mode;
	int failures = 0;
	int n_checks = 0;
	initial begin
		forever #20 clk_sys = ~clk_sys;
	end
	asf_dpath_model i_dp (.clk_sys(clk_sys), .op_valid(op_valid), .alu_op(alu_op),
		.opd_a(opd_a), .opd_b(opd_b), .src_is_flags(src_is_flags),
		.dest_is_flags(dest_is_flags), .addr_req(addr_req), .addr_mode(addr_mode),
		.addr_lit(addr_lit), .bank_sel(bank_sel), .fsr_ptr(fsr_ptr), .fsr2_ptr(fsr2_ptr));
	asf_flags #(.AW(12)) i_dut (.clk_sys(clk_sys), .rst(rst), .ext_strap(ext_strap),
		.op_valid(op_valid), .alu_op(alu_op), .opd_a(opd_a), .opd_b(opd_b),
		.src_is_flags(src_is_flags), .dest_is_flags(dest_is_flags), .addr_req(addr_req),
		.addr_mode(addr_mode), .addr_lit(addr_lit), .bank_sel(bank_sel),
		.fsr_ptr(fsr_ptr), .fsr2_ptr(fsr2_ptr), .flags_rd(flags_rd), .result_ff(result_ff),
		.data_addr_ff(data_addr_ff), .addr_vld_ff(addr_vld_ff), .addr_err_ff(addr_err_ff),
		.ext_set_active(ext_set_active));
	// ----------------------------------------
	// Checking tasks
	// ----------------------------------------
	task chk(input logic [13:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task alu(input asf_pkg::asf_op_e op, input logic [7:0] a, b, input logic s, d,
		input logic [7:0] er, ef);
		i_dp.exec(op, a, b, s, d);
		chk({6'h00, result_ff}, {6'h00, er});
		chk({6'h00, flags_rd}, {6'h00, ef});
	endtask : alu
	task adr(input asf_pkg::asf_mode_e m, input logic [7:0] lit, input logic [3:0] bk,
		input logic [13:0] exp);
		i_dp.resolve(m, lit, bk);
		chk({addr_vld_ff, addr_err_ff, data_addr_ff}, exp);
	endtask : adr
	task do_reset(input logic strap);
		@(negedge clk_sys);
		{rst, ext_strap} = {1'b1, strap};
		repeat (3) @(negedge clk_sys);
		rst = 1'b0;
		repeat (2) @(negedge clk_sys);
	endtask : do_reset
	task stop_test;
		$display("Checks %0d, failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : stop_test
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		do_reset(1'b0);
		chk({13'h0000, ext_set_active}, 14'h0000);
		alu(asf_pkg::ASF_OP_SUB, 8'h05, 8'h03, 1'b0, 1'b0, 8'h02, 8'h03);
		alu(asf_pkg::ASF_OP_SUB, 8'h03, 8'h05, 1'b0, 1'b0, 8'hFE, 8'h10);
		alu(asf_pkg::ASF_OP_ADD, 8'hFF, 8'h01, 1'b0, 1'b0, 8'h00, 8'h07);
		alu(asf_pkg::ASF_OP_ADDC, 8'h01, 8'h01, 1'b0, 1'b0, 8'h03, 8'h00);
		alu(asf_pkg::ASF_OP_SUBB, 8'h03, 8'h05, 1'b0, 1'b0, 8'hFD, 8'h10);
		alu(asf_pkg::ASF_OP_IOR, 8'h00, 8'h00, 1'b0, 1'b0, 8'h00, 8'h04);
		alu(asf_pkg::ASF_OP_ADD, 8'h7F, 8'h01, 1'b0, 1'b0, 8'h80, 8'h1A);
		alu(asf_pkg::ASF_OP_CLR, 8'h55, 8'h00, 1'b0, 1'b1, 8'h00, 8'h1E);
		alu(asf_pkg::ASF_OP_PASS, 8'hFF, 8'h00, 1'b0, 1'b1, 8'hFF, 8'h1F);
		alu(asf_pkg::ASF_OP_ADD, 8'h00, 8'h01, 1'b1, 1'b1, 8'h20, 8'h02);
		alu(asf_pkg::ASF_OP_XOR, 8'hF0, 8'hF0, 1'b0, 1'b0, 8'h00, 8'h06);
		alu(asf_pkg::ASF_OP_AND, 8'h8F, 8'hF0, 1'b0, 1'b0, 8'h80, 8'h12);
		alu(asf_pkg::ASF_OP_PASS, 8'h3C, 8'h00, 1'b0, 1'b0, 8'h3C, 8'h12);
		adr(asf_pkg::ASF_AM_BANKED, 8'h34, 4'h2, 14'h2234);
		adr(asf_pkg::ASF_AM_INHERENT, 8'h11, 4'h2, 14'h0234);
		adr(asf_pkg::ASF_AM_INDEXED, 8'h10, 4'h0, 14'h1808);
		adr(asf_pkg::ASF_AM_ACCESS, 8'h5F, 4'h0, 14'h205F);
		adr(asf_pkg::ASF_AM_ACCESS, 8'h60, 4'h0, 14'h2F60);
		adr(asf_pkg::ASF_AM_INDIRECT, 8'h00, 4'h0, 14'h23A5);
		adr(asf_pkg::ASF_AM_LITERAL, 8'h22, 4'h0, 14'h03A5);
		do_reset(1'b1);
		chk({6'h00, flags_rd}, 14'h0000);
		chk({13'h0000, ext_set_active}, 14'h0001);
		adr(asf_pkg::ASF_AM_INDEXED, 8'h10, 4'h0, 14'h2808);
		adr(asf_pkg::ASF_AM_ACCESS, 8'h20, 4'h0, 14'h2818);
		adr(asf_pkg::ASF_AM_ACCESS, 8'h80, 4'h0, 14'h2F80);
		stop_test();
	end
endmodule : alu_status_flags_bench

// [tb/asf_dpath_model.sv]
// Purpose: Instruction execution datapath model facing the flags block.
// Assumes: Requests change on the falling edge, one per task call.
// Notes:   Pointer values are plain defaults.
`timescale 1ns/100ps
module asf_dpath_model #(
	parameter logic [11:0] FSR_V  = 12'h3A5,
	parameter logic [11:0] FSR2_V = 12'h7F8
) (
	input  wire logic         clk_sys,
	output logic              op_valid,
	output asf_pkg::asf_op_e  alu_op,
	output logic [7:0]        opd_a,
	output logic [7:0]        opd_b,
	output logic              src_is_flags,
	output logic              dest_is_flags,
	output logic              addr_req,
	output asf_pkg::asf_mode_e addr_mode,
	output logic [7:0]        addr_lit,
	output logic [3:0]        bank_sel,
	output logic [11:0]       fsr_ptr,
	output logic [11:0]       fsr2_ptr
);
	initial begin
		{op_valid, src_is_flags, dest_is_flags, addr_req} = 4'h0;
		alu_op = asf_pkg::ASF_OP_PASS;
		addr_mode = asf_pkg::ASF_AM_INHERENT;
		{opd_a, opd_b, addr_lit, bank_sel} = 28'h0000000;
		fsr_ptr = FSR_V;
		fsr2_ptr = FSR2_V;
	end
	// Issues one instruction for one cycle.
	task exec(input asf_pkg::asf_op_e op, input logic [7:0] a, b, input logic s, d);
		@(negedge clk_sys);
		op_valid      = 1'b1;
		alu_op        = op;
		opd_a         = a;
		opd_b         = b;
		src_is_flags  = s;
		dest_is_flags = d;
		@(negedge clk_sys);
		op_valid = 1'b0;
	endtask : exec
	// Asks for one data address for one cycle.
	task resolve(input asf_pkg::asf_mode_e m, input logic [7:0] lit, input logic [3:0] bk);
		@(negedge clk_sys);
		addr_req  = 1'b1;
		addr_mode = m;
		addr_lit  = lit;
		bank_sel  = bk;
		@(negedge clk_sys);
		addr_req = 1'b0;
	endtask : resolve
endmodule : asf_dpath_model
